// ---- verilog/uart_mode_frame_control.sv ----
// Purpose: Mode, frame format and pin routing of the asynchronous serial unit.
// Assumes: One clock; pins pass a three-stage synchroniser before use.
// Notes: Every output is a field of the registered state record.
`timescale 1ns/1ns
`default_nettype none
module uart_mode_frame_control #(
  parameter int MIN_DIVISOR = 4
) (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEn,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regWmask,
  output logic [7:0] regRdata,
  // Port 1 pins
  input wire logic [7:0] port1In,
  output logic [7:0] port1Out,
  output logic [7:0] port1Oe,
  // Dedicated input pins and routed inputs
  input wire logic timerPinIn,
  input wire logic irqPinIn,
  output logic timerCaptureIn,
  output logic extIrqIn,
  // Event pulses
  output logic txDoneIrq,
  output logic rxDoneIrq,
  output logic rxErrIrq
);
  import uart_mode_pkg::*;

  if (MIN_DIVISOR != 4) begin : g_bad_div
    $error("MIN_DIVISOR must match the smallest divider the baud logic serves");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                       input logic [7:0] m);
    merge = (old & ~m) | (d & m);
  endfunction

  // Turns a character into its line order, least significant first when EXT_ORDER is set, else most significant first; self-inverse.
  function automatic logic [7:0] orderBits(input logic [7:0] d, input logic seven,
                                           input logic msb);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    if (!msb) begin
      orderBits = seven ? {1'b0, d[6:0]} : d;
    end else begin
      orderBits = seven ? {1'b0, r[7:1]} : r;
    end
  endfunction

  function automatic logic parityBit(input logic [7:0] d, input logic seven,
                                     input logic [1:0] sel);
    logic ones;
    ones = seven ? ^d[6:0] : ^d;
    case (sel)
      PAR_EVEN: parityBit = ones;
      PAR_ODD: parityBit = ~ones;
      default: parityBit = 1'b0;
    endcase
  endfunction

  state_t st_r;
  state_t st_nxt;
  logic power;
  logic txOn;
  logic rxOn;
  logic seven;
  logic msb;
  logic [1:0] par;
  logic [2:0] lastBit;
  logic [7:0] div;
  logic [8:0] bitTicks;
  logic [8:0] halfTicks;
  logic rxLine;
  logic [7:0] rxData;
  logic [2:0] rxErrNew;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.txDone = 1'b0;
    st_nxt.rxDone = 1'b0;
    st_nxt.rxErrIrq = 1'b0;
    rxData = 8'h00;
    rxErrNew = 3'b000;
    st_nxt.s1 = {irqPinIn, timerPinIn, port1In};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 10; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.filt[i] = st_r.s3[i];
      end
    end
    power = st_r.mode[MODE_POWER];
    txOn = power & st_r.mode[MODE_TXEN];
    rxOn = power & st_r.mode[MODE_RXEN];
    seven = ~st_r.mode[MODE_CHAR];
    msb = ~st_r.ext[EXT_ORDER];
    par = st_r.mode[4:3];
    lastBit = seven ? 3'd6 : 3'd7;
    div = (st_r.baud < MIN_DIV) ? MIN_DIV : st_r.baud;
    bitTicks = {div, 1'b0} - 9'd1;
    halfTicks = {1'b0, div} - 9'd1;
    rxLine = rxOn ? st_r.filt[RX_PIN] : 1'b1;

    // Transmitter.
    if (st_r.txState != TX_IDLE && st_r.txCnt != 9'd0) begin
      st_nxt.txCnt = st_r.txCnt - 9'd1;
    end else begin
      st_nxt.txCnt = bitTicks;
      case (st_r.txState)
        TX_IDLE: begin
          st_nxt.txLine = 1'b1;
          if (st_r.txBufFull) begin
            st_nxt.txShift = orderBits(st_r.txBuf, seven, msb);
            st_nxt.txPar = parityBit(st_r.txBuf, seven, par);
            st_nxt.txBufFull = 1'b0;
            st_nxt.txState = TX_START;
            st_nxt.txLine = 1'b0;
          end
        end
        TX_START: begin
          st_nxt.txState = TX_DATA;
          st_nxt.txLine = st_r.txShift[0];
          st_nxt.txShift = st_r.txShift >> 1;
          st_nxt.txBit = 3'd0;
        end
        TX_DATA: begin
          if (st_r.txBit == lastBit) begin
            st_nxt.txState = (par == PAR_NONE) ? TX_STOP : TX_PAR;
            st_nxt.txLine = (par == PAR_NONE) ? 1'b1 : st_r.txPar;
            st_nxt.txStop = 1'b0;
          end else begin
            st_nxt.txBit = st_r.txBit + 3'd1;
            st_nxt.txLine = st_r.txShift[0];
            st_nxt.txShift = st_r.txShift >> 1;
          end
        end
        TX_PAR: begin
          st_nxt.txState = TX_STOP;
          st_nxt.txLine = 1'b1;
          st_nxt.txStop = 1'b0;
        end
        TX_STOP: begin
          if (st_r.txStop == st_r.mode[MODE_STOP]) begin
            st_nxt.txState = TX_IDLE;
            st_nxt.txDone = 1'b1;
            st_nxt.txCnt = 9'd0;
          end else begin
            st_nxt.txStop = 1'b1;
          end
        end
        default: st_nxt.txState = TX_IDLE;
      endcase
    end

    // Register port; a buffer write after the load above is kept for the next frame.
    if (regWrite) begin
      case (regAddr)
        ADDR_PORT1_DIR: st_nxt.dir = merge(st_r.dir, regWdata, regWmask);
        ADDR_PORT1_LATCH: st_nxt.latch = merge(st_r.latch, regWdata, regWmask);
        ADDR_INPUT_SRC: st_nxt.srcSel = merge(st_r.srcSel, regWdata, regWmask & INPUT_SRC_WMASK);
        ADDR_MODE: st_nxt.mode = merge(st_r.mode, regWdata, regWmask);
        ADDR_BAUD: st_nxt.baud = merge(st_r.baud, regWdata, regWmask);
        ADDR_EXT: st_nxt.ext = merge(st_r.ext, regWdata, regWmask & EXT_WMASK);
        ADDR_TX_BUF: begin
          if (txOn) begin
            st_nxt.txBuf = regWdata;
            st_nxt.txBufFull = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        ADDR_PORT1_DIR: st_nxt.rdata = st_r.dir;
        ADDR_PORT1_LATCH: st_nxt.rdata = st_r.latch;
        ADDR_INPUT_SRC: st_nxt.rdata = st_r.srcSel;
        ADDR_MODE: st_nxt.rdata = st_r.mode;
        ADDR_BAUD: st_nxt.rdata = st_r.baud;
        ADDR_EXT: st_nxt.rdata = {st_r.ext[EXT_BRK_FLAG], 1'b0, st_r.ext[5:0]};
        ADDR_TX_STAT: st_nxt.rdata = {6'h00, st_r.txBufFull, st_r.txState != TX_IDLE};
        ADDR_RX_BUF: begin
          st_nxt.rdata = st_r.rxBuf;
          st_nxt.rxBufFull = 1'b0;
        end
        ADDR_RX_ERR: begin
          st_nxt.rdata = {5'h00, st_r.rxErr};
          st_nxt.rxErr = 3'b000;
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    // Receiver; it runs after the read clears so that a new event wins.
    st_nxt.rxPrev = rxLine;
    if (st_r.rxState != RX_IDLE && st_r.rxCnt != 9'd0) begin
      st_nxt.rxCnt = st_r.rxCnt - 9'd1;
    end else begin
      st_nxt.rxCnt = bitTicks;
      case (st_r.rxState)
        RX_IDLE: begin
          if (st_r.rxPrev && !rxLine) begin
            st_nxt.rxState = RX_START;
            st_nxt.rxCnt = halfTicks;
          end
        end
        RX_START: begin
          st_nxt.rxState = rxLine ? RX_IDLE : RX_DATA;
          st_nxt.rxBit = 3'd0;
        end
        RX_DATA: begin
          st_nxt.rxShift = {rxLine, st_r.rxShift[7:1]};
          st_nxt.rxBit = st_r.rxBit + 3'd1;
          if (st_r.rxBit == lastBit) begin
            st_nxt.rxState = (par == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR: begin
          st_nxt.rxPar = rxLine;
          st_nxt.rxState = RX_STOP;
        end
        RX_STOP: begin
          st_nxt.rxState = RX_IDLE;
          st_nxt.rxCnt = 9'd0;
          rxData = orderBits(seven ? {1'b0, st_r.rxShift[7:1]} : st_r.rxShift, seven, msb);
          rxErrNew[ERR_PARITY] = (par == PAR_EVEN || par == PAR_ODD) &&
                                 (parityBit(rxData, seven, par) != st_r.rxPar);
          rxErrNew[ERR_FRAMING] = ~rxLine;
          rxErrNew[ERR_OVERRUN] = st_nxt.rxBufFull;
          if (!st_nxt.rxBufFull) begin
            st_nxt.rxBuf = rxData;
            st_nxt.rxBufFull = 1'b1;
          end
          st_nxt.rxErr = st_nxt.rxErr | rxErrNew;
          if (rxErrNew != 3'b000 && !st_r.mode[MODE_ERR_ROUTE]) begin
            st_nxt.rxErrIrq = 1'b1;
          end else begin
            st_nxt.rxDone = 1'b1;
          end
        end
        default: st_nxt.rxState = RX_IDLE;
      endcase
    end

    // Enable and power side effects.
    if (!txOn) begin
      st_nxt.txState = TX_IDLE;
      st_nxt.txCnt = 9'd0;
      st_nxt.txLine = 1'b1;
      st_nxt.txBufFull = 1'b0;
      st_nxt.txDone = 1'b0;
    end
    if (!rxOn) begin
      st_nxt.rxState = RX_IDLE;
      st_nxt.rxCnt = 9'd0;
      st_nxt.rxPrev = 1'b1;
      st_nxt.rxDone = 1'b0;
      st_nxt.rxErrIrq = 1'b0;
    end
    if (!power) begin
      st_nxt.rxErr = 3'b000;
      st_nxt.txBufFull = 1'b0;
      st_nxt.ext[EXT_BRK_FLAG] = 1'b0;
      st_nxt.ext[EXT_BRK_TRIG] = 1'b0;
      st_nxt.rxBuf = 8'h00;
      st_nxt.rxBufFull = 1'b0;
      if (st_r.txState != TX_IDLE) begin
        st_nxt.txForceHi = 1'b1;
      end
    end else begin
      st_nxt.txForceHi = 1'b0;
    end

    // Pins and routed inputs.
    for (int i = 0; i < 8; i++) begin
      st_nxt.pinOe[i] = ~st_r.dir[i];
      st_nxt.pinOut[i] = st_r.latch[i];
    end
    if (txOn) begin
      st_nxt.pinOut[TX_PIN] = st_r.txLine ^ st_r.ext[EXT_INV];
    end else if (st_r.txForceHi) begin
      st_nxt.pinOut[TX_PIN] = 1'b1;
    end
    st_nxt.capIn = st_r.srcSel[SRC_CAPTURE] ? st_r.filt[RX_PIN] : st_r.filt[SYNC_TIMER];
    st_nxt.irqIn = st_r.srcSel[SRC_IRQ] ? st_r.filt[RX_PIN] : st_r.filt[SYNC_IRQ];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.dir <= PORT1_DIR_RST;
      st_r.latch <= PORT1_LATCH_RST;
      st_r.srcSel <= INPUT_SRC_RST;
      st_r.mode <= MODE_RST;
      st_r.baud <= BAUD_RST;
      st_r.ext <= EXT_RST;
      st_r.txLine <= 1'b1;
      st_r.rxPrev <= 1'b1;
      st_r.s1 <= 10'h3FF;
      st_r.s2 <= 10'h3FF;
      st_r.s3 <= 10'h3FF;
      st_r.filt <= 10'h3FF;
    end else if (clockEn) begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign port1Out = st_r.pinOut;
  assign port1Oe = st_r.pinOe;
  assign timerCaptureIn = st_r.capIn;
  assign extIrqIn = st_r.irqIn;
  assign txDoneIrq = st_r.txDone;
  assign rxDoneIrq = st_r.rxDone;
  assign rxErrIrq = st_r.rxErrIrq;
endmodule // uart_mode_frame_control
`default_nettype wire

// ---- verilog/uart_mode_pkg.sv ----
// Purpose: Constants, state codes and the state record of the serial mode/frame block.
// Assumes: Byte-wide memory-mapped register port on the peripheral clock.
// Notes: Offsets are byte addresses of the register port.
package uart_mode_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ADDR_PORT1_DIR = 16'hFF21;
  localparam logic [15:0] ADDR_PORT1_LATCH = 16'hFF01;
  localparam logic [15:0] ADDR_INPUT_SRC = 16'hFF4F;
  localparam logic [15:0] ADDR_MODE = 16'hFF50;
  localparam logic [15:0] ADDR_RX_BUF = 16'hFF52;
  localparam logic [15:0] ADDR_RX_ERR = 16'hFF53;
  localparam logic [15:0] ADDR_TX_BUF = 16'hFF55;
  localparam logic [15:0] ADDR_TX_STAT = 16'hFF56;
  localparam logic [15:0] ADDR_BAUD = 16'hFF57;
  localparam logic [15:0] ADDR_EXT = 16'hFF58;
  localparam logic [7:0] PORT1_DIR_RST = 8'hFF;
  localparam logic [7:0] PORT1_LATCH_RST = 8'h00;
  localparam logic [7:0] INPUT_SRC_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] BAUD_RST = 8'hFF;
  localparam logic [7:0] EXT_RST = 8'h16;
  localparam logic [7:0] INPUT_SRC_WMASK = 8'h03;
  localparam logic [7:0] EXT_WMASK = 8'h7F;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_POWER = 7;
  localparam int MODE_TXEN = 6;
  localparam int MODE_RXEN = 5;
  localparam int MODE_CHAR = 2;
  localparam int MODE_STOP = 1;
  localparam int MODE_ERR_ROUTE = 0;
  localparam int EXT_BRK_FLAG = 7;
  localparam int EXT_BRK_TRIG = 6;
  localparam int EXT_ORDER = 1;
  localparam int EXT_INV = 0;
  localparam int SRC_CAPTURE = 1;
  localparam int SRC_IRQ = 0;
  localparam int TX_PIN = 3;
  localparam int RX_PIN = 4;
  localparam int SYNC_TIMER = 8;
  localparam int SYNC_IRQ = 9;
  localparam int ERR_PARITY = 2;
  localparam int ERR_FRAMING = 1;
  localparam int ERR_OVERRUN = 0;
  localparam logic [1:0] PAR_NONE = 2'b00;
  localparam logic [1:0] PAR_ZERO = 2'b01;
  localparam logic [1:0] PAR_ODD = 2'b10;
  localparam logic [1:0] PAR_EVEN = 2'b11;
  localparam logic [7:0] MIN_DIV = 8'h04;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011, TX_STOP = 3'b100
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011, RX_STOP = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
    logic [7:0] srcSel;
    logic [7:0] mode;
    logic [7:0] baud;
    logic [7:0] ext;
    logic [7:0] txBuf;
    logic txBufFull;
    logic [7:0] txShift;
    logic txPar;
    tx_state_t txState;
    logic [8:0] txCnt;
    logic [2:0] txBit;
    logic txStop;
    logic txLine;
    logic txForceHi;
    rx_state_t rxState;
    logic [8:0] rxCnt;
    logic [2:0] rxBit;
    logic [7:0] rxShift;
    logic rxPar;
    logic rxPrev;
    logic [7:0] rxBuf;
    logic rxBufFull;
    logic [2:0] rxErr;
    logic [9:0] s1;
    logic [9:0] s2;
    logic [9:0] s3;
    logic [9:0] filt;
    logic [7:0] rdata;
    logic [7:0] pinOut;
    logic [7:0] pinOe;
    logic capIn;
    logic irqIn;
    logic txDone;
    logic rxDone;
    logic rxErrIrq;
  } state_t;

endpackage

// ---- verification/uart_mode_frame_control_assertions.sv ----
// Purpose: Port-level checks of the serial mode and frame block.
// Assumes: One clock domain; reset_n is asynchronous and active low.
// Notes: Bound to the block; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module uart_mode_frame_control_assertions #(
  parameter int MIN_DIVISOR = 4
) (
  // Clock and control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEn,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regWmask,
  input wire logic [7:0] regRdata,
  // Pins and events
  input wire logic [7:0] port1In,
  input wire logic [7:0] port1Out,
  input wire logic [7:0] port1Oe,
  input wire logic timerPinIn,
  input wire logic irqPinIn,
  input wire logic timerCaptureIn,
  input wire logic extIrqIn,
  input wire logic txDoneIrq,
  input wire logic rxDoneIrq,
  input wire logic rxErrIrq
);
  import uart_mode_pkg::*;

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Saturates so that the first frame after reset never looks too short.
  logic [15:0] sinceTx_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sinceTx_r <= 16'hFFFF;
    end else if (txDoneIrq) begin
      sinceTx_r <= 16'h0000;
    end else if (sinceTx_r != 16'hFFFF) begin
      sinceTx_r <= sinceTx_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_reset_quiet: assert property (@(posedge clock)
    !reset_n |-> regRdata == 8'h00 && port1Oe == 8'h00 && port1Out == 8'h00 && !txDoneIrq)
    else $error("outputs active during reset");
  chk_read_holds: assert property (@(posedge clock) disable iff (!reset_n)
    !(regRead && clockEn) |=> $stable(regRdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (@(posedge clock) disable iff (!reset_n)
    regRead && clockEn && regAddr[15:8] != 8'hFF |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_source_reserved: assert property (@(posedge clock) disable iff (!reset_n)
    regRead && clockEn && regAddr == ADDR_INPUT_SRC |=> regRdata[7:2] == 6'h00)
    else $error("reserved source bits read nonzero");
  chk_trigger_reads_zero: assert property (@(posedge clock) disable iff (!reset_n)
    regRead && clockEn && regAddr == ADDR_EXT |=> regRdata[EXT_BRK_TRIG] == 1'b0)
    else $error("break trigger read nonzero");
  chk_tx_frame_gap: assert property (@(posedge clock) disable iff (!reset_n)
    txDoneIrq |-> sinceTx_r >= 16 * MIN_DIVISOR)
    else $error("transmit pulses closer than one frame");
  chk_rx_pulse_gap: assert property (@(posedge clock) disable iff (!reset_n)
    rxDoneIrq || rxErrIrq |=> !(rxDoneIrq || rxErrIrq) [*8])
    else $error("receive pulse too long");
  chk_rx_one_event: assert property (@(posedge clock) disable iff (!reset_n)
    rxErrIrq |-> !rxDoneIrq)
    else $error("both receive pulses together");
  chk_freeze_outputs: assert property (@(posedge clock) disable iff (!reset_n)
    !clockEn |=> $stable(port1Out) && $stable(port1Oe) && $stable(regRdata))
    else $error("outputs moved while frozen");

  cov_tx_done: cover property (@(posedge clock) disable iff (!reset_n) txDoneIrq);
  cov_rx_done: cover property (@(posedge clock) disable iff (!reset_n) rxDoneIrq);
  cov_rx_err: cover property (@(posedge clock) disable iff (!reset_n) rxErrIrq);
endmodule // uart_mode_frame_control_assertions

bind uart_mode_frame_control uart_mode_frame_control_assertions #(
  .MIN_DIVISOR(MIN_DIVISOR)
) checker_i (
  .clock(clock), .reset_n(reset_n), .clockEn(clockEn), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regWmask(regWmask),
  .regRdata(regRdata), .port1In(port1In), .port1Out(port1Out), .port1Oe(port1Oe),
  .timerPinIn(timerPinIn), .irqPinIn(irqPinIn), .timerCaptureIn(timerCaptureIn),
  .extIrqIn(extIrqIn), .txDoneIrq(txDoneIrq), .rxDoneIrq(rxDoneIrq), .rxErrIrq(rxErrIrq)
);
`default_nettype wire

// ---- verification/uart_line_peer.sv ----
// Purpose: Remote serial station on the line side of the block.
// Assumes: Bit time is BIT_CLKS clocks; the line is pulled to mark.
// Notes: The bench calls its tasks; the line stands at mark between frames.
`timescale 1ns/1ns
`default_nettype none
module uart_line_peer #(
  parameter int BIT_CLKS = 8
) (
  // Clock and line
  input wire logic clock,
  input wire logic lineIn,
  output var logic lineOut
);
  initial lineOut = 1'b1;

  task automatic level(input logic v);
    @(posedge clock);
    #1 lineOut = v;
  endtask

  // Bit 0 leaves first; the caller supplies start, parity and stop bits.
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1 lineOut = bits[i];
      repeat (BIT_CLKS - 1) @(posedge clock);
    end
    @(posedge clock);
    #1 lineOut = 1'b1;
  endtask

  // Samples mid-bit, so a one-clock slip in spotting the start edge is harmless.
  task automatic grab(input int n, input logic inv, output logic [11:0] bits);
    int t;
    bits = 12'hFFF;
    // Looks 1 ns after each edge, clear of the block's own register updates.
    for (t = 0; t < 4000 && (lineIn ^ inv) !== 1'b0; t++) begin
      @(posedge clock);
      #1;
    end
    if (t < 4000) begin
      // Returns right after the last sample so that the caller still sees the done pulse.
      for (int i = 0; i < n; i++) begin
        repeat (i == 0 ? BIT_CLKS / 2 : BIT_CLKS) @(posedge clock);
        #1;
        bits[i] = lineIn ^ inv;
      end
    end
  endtask
endmodule // uart_line_peer
`default_nettype wire

// ---- verification/tb.sv ----
// Purpose: Self-checking bench of the serial mode and frame block.
// Assumes: Baud divider 4, so one bit lasts 8 clocks.
// Notes: Frames run both ways through the line peer.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import uart_mode_pkg::*;

  localparam int BIT_CLKS = 8;
  localparam logic [7:0] CFG_MODE [4] = '{8'h1C, 8'h12, 8'h0C, 8'h06};
  localparam logic [7:0] CFG_EXT [4] = '{8'h02, 8'h03, 8'h00, 8'h01};
  localparam logic [7:0] CFG_DATA [4] = '{8'h55, 8'h36, 8'h87, 8'hC3};
  logic clock = 1'b0;
  logic reset_n = 1'b1;
  logic clockEn = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regWmask = 8'h00;
  logic timerPinIn = 1'b1;
  logic irqPinIn = 1'b1;
  logic [7:0] regRdata, port1Out, port1Oe, pinWire;
  logic timerCaptureIn, extIrqIn, txDoneIrq, rxDoneIrq, rxErrIrq, peerLine;
  int mismatches = 0;
  int compares = 0;

  always #2 clock = ~clock;
  // Released pins float to the pull-up; the receive pin is the peer's line.
  assign pinWire = (port1Oe & port1Out) | (~port1Oe & {3'h7, peerLine, 4'hF});

  uart_mode_frame_control #(.MIN_DIVISOR(4)) DUT (
    .clock(clock), .reset_n(reset_n), .clockEn(clockEn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regWmask(regWmask),
    .regRdata(regRdata), .port1In(pinWire), .port1Out(port1Out), .port1Oe(port1Oe),
    .timerPinIn(timerPinIn), .irqPinIn(irqPinIn), .timerCaptureIn(timerCaptureIn),
    .extIrqIn(extIrqIn), .txDoneIrq(txDoneIrq), .rxDoneIrq(rxDoneIrq), .rxErrIrq(rxErrIrq)
  );
  uart_line_peer #(.BIT_CLKS(BIT_CLKS)) peer (
    .clock(clock), .lineIn(pinWire[3]), .lineOut(peerLine)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clock);
    #1;
    regAddr = a;
    regWdata = d;
    regWmask = m;
    regWrite = 1'b1;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string what);
    @(posedge clock);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clock);
    #1;
    regRead = 1'b0;
    check({4'h0, regRdata}, {4'h0, e}, what);
  endtask

  // Waits for the transmit pulse (which 0) or either receive pulse.
  task automatic wait_for(input int which, input int lim);
    int t;
    for (t = 0; t < lim; t++) begin
      @(posedge clock);
      #1;
      if (which == 0 ? txDoneIrq === 1'b1 : (rxDoneIrq === 1'b1 || rxErrIrq === 1'b1)) break;
    end
    if (t >= lim) begin
      mismatches++;
      $display("wrong value at %0t: wait ran out", $time);
      tally_and_finish;
    end
  endtask

  // Returns the frame length above the line bits, bit 0 first on the line.
  function automatic logic [15:0] frame(input logic [7:0] d, input logic [7:0] m,
                                        input logic [7:0] x);
    logic [11:0] b;
    int nc;
    int n;
    logic par;
    b = 12'hFFE;
    nc = m[2] ? 8 : 7;
    par = ^(d & (m[2] ? 8'hFF : 8'h7F));
    for (int j = 0; j < nc; j++) b[1 + j] = x[1] ? d[j] : d[nc - 1 - j];
    n = 1 + nc;
    if (m[4:3] != 2'b00) begin
      b[n] = m[4] & (par ^ ~m[3]);
      n++;
    end
    n = n + (m[1] ? 2 : 1);
    return {n[3:0], b};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] f;
    logic [11:0] got;
    // Reset falls before the first edge so that no edge samples unknown state.
    #1;
    reset_n = 1'b0;
    repeat (16) @(posedge clock);
    #1;
    reset_n = 1'b1;
    rdchk(ADDR_MODE, 8'h01, "mode reset");
    rdchk(ADDR_PORT1_DIR, 8'hFF, "direction reset");
    rdchk(ADDR_INPUT_SRC, 8'h00, "source reset");
    rdchk(ADDR_EXT, 8'h16, "control reset");
    rdchk(16'h0000, 8'h00, "unmapped read");
    check({4'h0, port1Oe}, 12'h000, "pins released");
    clockEn = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    clockEn = 1'b1;
    wr(ADDR_MODE, 8'h00, 8'h01);
    rdchk(ADDR_MODE, 8'h00, "mode bit write");
    wr(ADDR_INPUT_SRC, 8'hFF, 8'hFF);
    rdchk(ADDR_INPUT_SRC, 8'h03, "source writable bits");
    peer.level(1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_INPUT_SRC, s[7:0], 8'hFF);
      repeat (6) @(posedge clock);
      #1;
      check({10'h0, timerCaptureIn, extIrqIn}, {10'h0, ~s[1], ~s[0]}, "routing");
    end
    peer.level(1'b1);
    wr(ADDR_PORT1_LATCH, 8'h08, 8'h08);
    wr(ADDR_PORT1_DIR, 8'h00, 8'h08);
    repeat (2) @(posedge clock);
    #1;
    check({4'h0, port1Oe}, 12'h008, "direction to enable");
    wr(ADDR_BAUD, 8'h04, 8'hFF);
    for (int c = 0; c < 4; c++) begin
      f = frame(CFG_DATA[c], CFG_MODE[c], CFG_EXT[c]);
      wr(ADDR_MODE, 8'h00, 8'h60);
      wr(ADDR_MODE, 8'h00, 8'h80);
      wr(ADDR_MODE, CFG_MODE[c], 8'h1F);
      wr(ADDR_EXT, CFG_EXT[c], 8'h03);
      wr(ADDR_MODE, 8'h80, 8'h80);
      wr(ADDR_MODE, 8'h60, 8'h60);
      repeat (2) @(posedge clock);
      #1;
      check({11'h0, port1Out[3]}, {11'h0, ~CFG_EXT[c][0]}, "idle mark");
      fork
        peer.grab(int'(f[15:12]), CFG_EXT[c][0], got);
        wr(ADDR_TX_BUF, CFG_DATA[c], 8'hFF);
      join
      check(got, f[11:0], "sent frame");
      wait_for(0, 4 * BIT_CLKS);
      fork
        peer.send(f[11:0], int'(f[15:12]));
        wait_for(1, 16 * BIT_CLKS);
      join
      rdchk(ADDR_RX_BUF, CFG_DATA[c] & (CFG_MODE[c][2] ? 8'hFF : 8'h7F), "rx byte");
      rdchk(ADDR_RX_ERR, 8'h00, "clean frame");
      if (CFG_MODE[c][4:3] != 2'b00) begin
        fork
          peer.send(f[11:0] ^ (12'h001 << (CFG_MODE[c][2] ? 9 : 8)), int'(f[15:12]));
          wait_for(1, 16 * BIT_CLKS);
        join
        rdchk(ADDR_RX_BUF, CFG_DATA[c] & (CFG_MODE[c][2] ? 8'hFF : 8'h7F), "rx byte 2");
        rdchk(ADDR_RX_ERR, {5'h00, CFG_MODE[c][4], 2'b00}, "parity check");
      end
    end
    wr(ADDR_TX_BUF, 8'hA5, 8'hFF);
    wr(ADDR_TX_BUF, 8'h5A, 8'hFF);
    rdchk(ADDR_TX_STAT, 8'h03, "buffer and shifter busy");
    wr(ADDR_MODE, 8'h00, 8'h40);
    rdchk(ADDR_TX_STAT, 8'h00, "transmit reset");
    wr(ADDR_MODE, 8'h40, 8'h40);
    fork
      peer.send(f[11:0] ^ 12'h200, int'(f[15:12]));
      wait_for(1, 16 * BIT_CLKS);
    join
    wr(ADDR_TX_BUF, 8'hA5, 8'hFF);
    repeat (20) @(posedge clock);
    // A low latch makes the forced-high pin visible.
    wr(ADDR_PORT1_LATCH, 8'h00, 8'h08);
    // All three bits cleared at once, so the frame is cut in flight.
    wr(ADDR_MODE, 8'h00, 8'hE0);
    repeat (2) @(posedge clock);
    #1;
    check({11'h0, port1Out[3]}, 12'h001, "pin high after power off");
    rdchk(ADDR_RX_ERR, 8'h00, "error status cleared");
    rdchk(ADDR_RX_BUF, 8'h00, "receive buffer cleared");
    rdchk(ADDR_TX_STAT, 8'h00, "transmit status cleared");
    wr(ADDR_MODE, 8'h80, 8'h80);
    repeat (2) @(posedge clock);
    #1;
    check({11'h0, port1Out[3]}, 12'h000, "latch while transmit off");
    wr(ADDR_MODE, 8'h00, 8'h80);
    wr(ADDR_PORT1_LATCH, 8'h08, 8'h08);
    repeat (2) @(posedge clock);
    #1;
    check({11'h0, port1Out[3]}, 12'h001, "port pin when stopped");
    tally_and_finish;
  end

  initial begin
    #200000;
    mismatches++;
    $display("wrong value at %0t: run too long", $time);
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
